// ===== hw/bpsc_core.v
// Bias power path, switched rail and programmable current source control
//
// Overview of operation
// R1: Turn-on opens both start-up path switches; the code drives both high (closed) in start-up
// R2: After start-up, regulator drives gate rail
// R3: Tuning target 8.5 V or 4 V
// R4: Gate rail open/short at start-up faults
// R5: Gate rail above 15 V in run faults
// R6: Zero-crossing then switch-node event trims on-time
// R7: Run high closes switched-rail switch
// R8: Run low keeps switched-rail switch open
// R9: Low-side waits for switched rail above 10 V
// R10: Switched rail off before turn-on threshold
// R11: Loads on switched rail power up within 2 us
// R12: Sample winding sense during demagnetization
// R13: Sample below 2.4 V sets low-output flag
// R14: Sample above 2.5 V clears low-output flag
// R15: Low-output flag enables source in run
// R16: Otherwise source only in second standby run
// R17: Source always off in wait state
// R18: Supply below 13 V stops source
// R19: Run low disables all drive switching
// R20: Undervoltage lockout at 17 V on, 10.6 V off
// R21: Between thresholds the flag holds
`include "bpsc_regs.vh"

module bpsc_core (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] vdd_lvl_i,
  input  wire [7:0] gate_rail_lvl_i,
  input  wire [7:0] switched_rail_lvl_i,
  input  wire [7:0] winding_sense_lvl_i,
  input  wire [7:0] tune_sel_lvl_i,
  input  wire       gate_rail_open_i,
  input  wire       gate_rail_short_i,
  input  wire       run_i,
  input  wire [2:0] mode_i,
  input  wire       demag_i,
  input  wire       zcd_i,
  input  wire       sws_det_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  output reg        startup_sws_sw_o,
  output reg        startup_gate_sw_o,
  output reg        reg_gate_sw_o,
  output reg        switched_rail_sw_o,
  output reg        low_side_en_o,
  output reg        high_side_en_o,
  output reg  [7:0] ontime_o,
  output reg  [7:0] tune_thr_o,
  output wire       low_output_indication_o,
  output reg        prog_src_en_o,
  output reg        survival_stop_o,
  output reg        fault_o
);

  localparam ST_START  = 2'b00;
  localparam ST_ACTIVE = 2'b01;
  localparam ST_FAULT  = 2'b10;

  function above;
    input [7:0] lvl;
    input [7:0] thr;
    begin
      above = (lvl > thr);
    end
  endfunction

  function below;
    input [7:0] lvl;
    input [7:0] thr;
    begin
      below = (lvl < thr);
    end
  endfunction

  // Saturating trim step
  function [7:0] trim;
    input [7:0] val;
    input [3:0] stp;
    input       up;
    reg   [8:0] sum;
    begin
      if (up) begin
        sum  = {1'b0, val} + {5'h00, stp};
        trim = sum[8] ? 8'hFF : sum[7:0];
      end else begin
        trim = (val < {4'h0, stp}) ? 8'h00 : (val - {4'h0, stp});
      end
    end
  endfunction

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] ctrl;
  reg  [3:0] step;
  reg  [7:0] sample;
  reg  [1:0] cause;
  reg  [7:0] bursts;
  reg        run_q;
  reg        ls_hold;
  reg        armed;
  wire       uvlo_on;
  wire       low_flag;
  wire       pin_fault;
  wire       ov_fault;
  wire       run_state;
  wire       rail_good;
  wire       next_ls_hold;
  wire       next_surv;
  wire       normal_mode;
  wire       next_src_en;
  wire       tune_en;
  wire       burst_start;

  // Supply undervoltage lockout
  bpsc_hyst #(
    .LO  (`BPSC_VDD_OFF),
    .HI  (`BPSC_VDD_ON),
    .INV (0)
  ) u_uvlo (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .lvl_i    (vdd_lvl_i),
    .flag_o   (uvlo_on)
  ); // [R20]

  // Low-output indication from the demagnetization sample
  bpsc_hyst #(
    .LO  (`BPSC_LOWOUT_LR),
    .HI  (`BPSC_LOWOUT_UP),
    .INV (1)
  ) u_lowout (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .lvl_i    (sample),
    .flag_o   (low_flag)
  ); // [R13] [R14] [R21]

  assign low_output_indication_o = low_flag;

  assign pin_fault = gate_rail_open_i | gate_rail_short_i;
  assign ov_fault  = run_i & above(gate_rail_lvl_i, `BPSC_GATE_OV);
  assign rail_good = above(switched_rail_lvl_i, `BPSC_RAIL_OK);
  assign tune_en   = ctrl[`BPSC_CTRL_TUNE_EN];

  // Operating state sequence
  always @* begin
    next_state = state;
    case (state)
      ST_START: begin
        if (pin_fault) begin
          next_state = ST_FAULT; // [R4]
        end else if (uvlo_on) begin
          next_state = ST_ACTIVE; // [R1] [R2]
        end
      end
      ST_ACTIVE: begin
        if (!uvlo_on) begin
          next_state = ST_START;
        end else if (ov_fault) begin
          next_state = ST_FAULT; // [R5]
        end
      end
      ST_FAULT: begin
        if (below(vdd_lvl_i, `BPSC_VDD_OFF)) begin
          next_state = ST_START;
        end
      end
      default: begin
        next_state = ST_START;
      end
    endcase
  end

  // Run state versus low-current wait state
  assign run_state   = (next_state == ST_ACTIVE) & run_i; // [R19]
  assign burst_start = run_i & ~run_q;

  // Low-side hold from burst start until the switched rail is good
  assign next_ls_hold = ~run_state | (ls_hold & ~rail_good); // [R9]

  assign next_surv   = below(vdd_lvl_i, `BPSC_VDD_SURV); // [R18]
  assign normal_mode = (mode_i <= `BPSC_MODE_AMPL);

  // Programmable current source enable
  assign next_src_en = run_state & ~next_surv & normal_mode &
                       (low_flag | (mode_i == `BPSC_MODE_STBY2)); // [R15] [R16] [R17] [R18]

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_START;
    end else begin
      state <= next_state;
    end
  end

  // Power path switches and drive gates
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      startup_sws_sw_o   <= 1'b1;
      startup_gate_sw_o  <= 1'b1;
      reg_gate_sw_o      <= 1'b0;
      switched_rail_sw_o <= 1'b0;
      low_side_en_o      <= 1'b0;
      high_side_en_o     <= 1'b0;
      fault_o            <= 1'b0;
      ls_hold            <= 1'b1;
      run_q              <= 1'b0;
    end else begin
      startup_sws_sw_o   <= (next_state == ST_START); // [R1]
      startup_gate_sw_o  <= (next_state == ST_START); // [R1]
      reg_gate_sw_o      <= (next_state == ST_ACTIVE); // [R2]
      switched_rail_sw_o <= run_state; // [R7] [R8] [R10]
      low_side_en_o      <= run_state & ~next_ls_hold; // [R9] [R19]
      high_side_en_o     <= run_state; // [R19]
      fault_o            <= (next_state == ST_FAULT); // [R4] [R5]
      ls_hold            <= next_ls_hold;
      run_q              <= run_i;
    end
  end

  // Winding sense sample, survival flag and source enable
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample          <= 8'hFF;
      survival_stop_o <= 1'b0;
      prog_src_en_o   <= 1'b0;
    end else begin
      if (demag_i) begin
        sample <= winding_sense_lvl_i; // [R12]
      end
      survival_stop_o <= next_surv; // [R18]
      prog_src_en_o   <= next_src_en; // [R15] [R16] [R17]
    end
  end

  // Tuning target selection
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tune_thr_o <= `BPSC_TUNE_THR_LO;
    end else if (above(tune_sel_lvl_i, `BPSC_TUNE_SEL_MID)) begin
      tune_thr_o <= `BPSC_TUNE_THR_HI; // [R3]
    end else begin
      tune_thr_o <= `BPSC_TUNE_THR_LO; // [R3]
    end
  end

  // High-side on-time trim: zero-crossing arms, switch-node event must follow
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ontime_o <= `BPSC_ONTIME_RST;
      armed    <= 1'b0;
    end else if (!tune_en || !run_state) begin
      armed <= 1'b0;
    end else if (zcd_i) begin
      if (armed) begin
        ontime_o <= trim(ontime_o, step, 1'b1); // [R6]
      end
      armed <= 1'b1;
    end else if (sws_det_i && armed) begin
      ontime_o <= trim(ontime_o, step, 1'b0); // [R6]
      armed    <= 1'b0;
    end
  end

  // Fault cause, held until the next fault or reset
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cause <= 2'b00;
    end else if (state == ST_START && next_state == ST_FAULT) begin
      cause <= 2'b01; // [R4]
    end else if (state == ST_ACTIVE && next_state == ST_FAULT) begin
      cause <= 2'b10; // [R5]
    end
  end

  // Burst counter
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bursts <= 8'h00;
    end else if (burst_start && next_state == ST_ACTIVE) begin
      bursts <= bursts + 8'h01;
    end
  end

  // Register writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= `BPSC_CTRL_RST;
      step <= `BPSC_STEP_RST;
    end else if (wr_i) begin
      case (addr_i)
        `BPSC_ADDR_CTRL: begin
          ctrl <= {7'h00, wdata_i[`BPSC_CTRL_TUNE_EN]};
        end
        `BPSC_ADDR_STEP: begin
          step <= wdata_i[3:0];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Register reads, data valid in the cycle after the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `BPSC_ADDR_CTRL: begin
          rdata_o <= ctrl;
        end
        `BPSC_ADDR_STEP: begin
          rdata_o <= {4'h0, step};
        end
        `BPSC_ADDR_STAT: begin
          rdata_o <= {ls_hold, rail_good, prog_src_en_o, survival_stop_o,
                      low_flag, uvlo_on, state};
        end
        `BPSC_ADDR_ONTIME: begin
          rdata_o <= ontime_o;
        end
        `BPSC_ADDR_SAMPLE: begin
          rdata_o <= sample;
        end
        `BPSC_ADDR_TUNE: begin
          rdata_o <= tune_thr_o;
        end
        `BPSC_ADDR_CAUSE: begin
          rdata_o <= {6'h00, cause};
        end
        `BPSC_ADDR_BURSTS: begin
          rdata_o <= bursts;
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// ===== hw/bpsc_regs.vh
// Register offsets, fields, reset values and thresholds of the bias path sequencer
`ifndef BPSC_REGS_VH
`define BPSC_REGS_VH

// Voltage codes in units of 0.1 V
`define BPSC_VDD_ON       8'hAA
`define BPSC_VDD_OFF      8'h6A
`define BPSC_VDD_SURV     8'h82
`define BPSC_GATE_OV      8'h96
`define BPSC_RAIL_OK      8'h64
`define BPSC_LOWOUT_LR    8'h18
`define BPSC_LOWOUT_UP    8'h19
`define BPSC_TUNE_THR_HI  8'h55
`define BPSC_TUNE_THR_LO  8'h28
`define BPSC_TUNE_SEL_MID 8'h19

// Control modes
`define BPSC_MODE_STBY1   3'h0
`define BPSC_MODE_STBY2   3'h1
`define BPSC_MODE_LOWPWR  3'h2
`define BPSC_MODE_BURST   3'h3
`define BPSC_MODE_AMPL    3'h4

// Register offsets
`define BPSC_ADDR_CTRL    4'h0
`define BPSC_ADDR_STEP    4'h1
`define BPSC_ADDR_STAT    4'h2
`define BPSC_ADDR_ONTIME  4'h3
`define BPSC_ADDR_SAMPLE  4'h4
`define BPSC_ADDR_TUNE    4'h5
`define BPSC_ADDR_CAUSE   4'h6
`define BPSC_ADDR_BURSTS  4'h7

// Field positions
`define BPSC_CTRL_TUNE_EN 0
`define BPSC_STAT_UVLO    2
`define BPSC_STAT_LOWOUT  3
`define BPSC_STAT_SURV    4
`define BPSC_STAT_SRC_EN  5
`define BPSC_STAT_RAIL_OK 6
`define BPSC_STAT_LS_HOLD 7
`define BPSC_CAUSE_PIN    0
`define BPSC_CAUSE_OV     1

// Reset values
`define BPSC_CTRL_RST     8'h01
`define BPSC_STEP_RST     4'h1
`define BPSC_ONTIME_RST   8'h40

`endif

// ===== hw/bpsc_hyst.v
// Threshold comparator with hysteresis held in a flip-flop
module bpsc_hyst #(
  parameter [7:0] LO  = 8'h00,
  parameter [7:0] HI  = 8'hFF,
  parameter       INV = 0
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] lvl_i,
  output reg        flag_o
);

  wire set_c;
  wire clr_c;

  // Normal: set at or above HI, clear below LO; inverted: set below LO, clear above HI
  assign set_c = INV ? (lvl_i < LO) : (lvl_i >= HI);
  assign clr_c = INV ? (lvl_i > HI) : (lvl_i < LO);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
    end else if (set_c) begin
      flag_o <= 1'b1;
    end else if (clr_c) begin
      flag_o <= 1'b0;
    end
  end

endmodule

// ===== tb/bpsc_core_assertions.sv
// Port checks for the bias path sequencer
module bpsc_chk (
  input logic       clk_i,
  input logic       resetn_i,
  input logic [7:0] vdd_lvl_i,
  input logic [7:0] gate_rail_lvl_i,
  input logic [7:0] switched_rail_lvl_i,
  input logic [7:0] winding_sense_lvl_i,
  input logic       run_i,
  input logic       demag_i,
  input logic       startup_sws_sw_o,
  input logic       startup_gate_sw_o,
  input logic       reg_gate_sw_o,
  input logic       switched_rail_sw_o,
  input logic       low_side_en_o,
  input logic       high_side_en_o,
  input logic       low_output_indication_o,
  input logic       prog_src_en_o,
  input logic       survival_stop_o,
  input logic       fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_path_swap: assert property (
    reg_gate_sw_o |-> !startup_sws_sw_o && !startup_gate_sw_o) else $error("paths overlap");
  a_rail_preon: assert property (
    startup_sws_sw_o |-> !switched_rail_sw_o) else $error("rail on in start-up");
  a_ov_fault: assert property (
    reg_gate_sw_o && run_i && gate_rail_lvl_i > 8'h96 |-> ##[1:2] fault_o)
    else $error("no overvoltage fault");
  a_ls_hold: assert property (
    $rose(low_side_en_o) |-> $past(switched_rail_lvl_i) > 8'h64) else $error("early low side");
  a_run_low: assert property (
    !run_i |=> !switched_rail_sw_o && !low_side_en_o && !high_side_en_o)
    else $error("active while run low");
  a_src_wait: assert property (
    !run_i |=> !prog_src_en_o) else $error("source on in wait");
  a_surv_stop: assert property (
    vdd_lvl_i < 8'h82 |=> survival_stop_o && !prog_src_en_o) else $error("no survival stop");
  a_low_set: assert property (
    demag_i && winding_sense_lvl_i < 8'h18 |-> ##2 low_output_indication_o)
    else $error("flag not set");
  a_low_clr: assert property (
    demag_i && winding_sense_lvl_i > 8'h19 |-> ##2 !low_output_indication_o)
    else $error("flag not cleared");
endmodule

bind bpsc_core bpsc_chk u_chk (.*);

// ===== tb/bpsc_rail_model.sv
// Switched rail with its load, as seen from outside
module bpsc_rail_model (
  input  logic       clk_i,
  input  logic       sw_i,
  output logic [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lvl_o = 8'h00;
  // Soft-start charge to 13 V, load ready once good load discharge only
  always @(posedge clk_i)
    if (sw_i) lvl_o <= (lvl_o > 8'h72) ? 8'h82 : lvl_o + 8'h10;
    else lvl_o <= (lvl_o > 8'h08) ? lvl_o - 8'h08 : 8'h00;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the bias path sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i, resetn_i, run_i, demag_i, zcd_i, sws_i, wr_i, rd_i, opn, sht;
  logic       ssw, sgw, rgw, rsw, ls, hs, low, src, surv, flt;
  logic [2:0] mode;
  logic [3:0] addr;
  logic [7:0] vdd, gr, sr, ws, ts, wdata, rdata, ont, thr;
  logic [7:0] lvs [5] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h19};
  logic [7:0] vth [4] = '{8'hA9, 8'hAA, 8'h6A, 8'h69};
  int         error_cnt, check_count;
  bpsc_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .vdd_lvl_i(vdd), .gate_rail_lvl_i(gr),
    .switched_rail_lvl_i(sr), .winding_sense_lvl_i(ws), .tune_sel_lvl_i(ts),
    .gate_rail_open_i(opn), .gate_rail_short_i(sht), .run_i(run_i), .mode_i(mode),
    .demag_i(demag_i), .zcd_i(zcd_i), .sws_det_i(sws_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .startup_sws_sw_o(ssw), .startup_gate_sw_o(sgw),
    .reg_gate_sw_o(rgw), .switched_rail_sw_o(rsw), .low_side_en_o(ls), .high_side_en_o(hs),
    .ontime_o(ont), .tune_thr_o(thr), .low_output_indication_o(low), .prog_src_en_o(src),
    .survival_stop_o(surv), .fault_o(flt));
  bpsc_rail_model u_rail (.clk_i(clk_i), .sw_i(rsw), .lvl_o(sr));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    cyc(1);
    chk(rdata, exp);
  endtask
  task dm(input logic [7:0] lvl);
    @(posedge clk_i);
    ws <= lvl;
    demag_i <= 1'b1;
    @(posedge clk_i);
    demag_i <= 1'b0;
    ws <= ~lvl;
    cyc(3);
  endtask
  task summarize();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    summarize();
  end
  initial begin
    {run_i, demag_i, zcd_i, sws_i, wr_i, rd_i, opn, sht, mode, addr, wdata, ws, ts} = '0;
    resetn_i = 1'b0;
    vdd = 8'h80;
    gr = 8'h82;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(1);
    chk({ont, thr}, 16'h4028);
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h01);
    rd(4'h8, 8'h00);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'h40);
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h02);
    @(posedge clk_i);
    run_i <= 1'b1;
    cyc(4);
    chk({ssw, sgw, rgw, rsw}, 8'h0C);
    @(posedge clk_i);
    vdd <= 8'hAA;
    cyc(4);
    chk({ssw, sgw, rgw, rsw, ls, hs}, 8'h0D);
    cyc(10);
    chk(ls, 8'h01);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      ts <= 8'h1A - i[7:0];
      cyc(3);
      chk(thr, i ? 8'h28 : 8'h55);
    end
    @(posedge clk_i);
    zcd_i <= 1'b1;
    @(posedge clk_i);
    zcd_i <= 1'b0;
    sws_i <= 1'b1;
    @(posedge clk_i);
    sws_i <= 1'b0;
    cyc(3);
    chk(ont, 8'h3E);
    repeat (2) begin
      @(posedge clk_i);
      zcd_i <= 1'b1;
      @(posedge clk_i);
      zcd_i <= 1'b0;
    end
    cyc(2);
    chk(ont, 8'h40);
    for (int i = 0; i < 5; i++) begin
      dm(lvs[i]);
      chk(low, (i < 3) ? 8'h01 : 8'h00);
      for (int m = 0; m < 6 && i % 2 == 0; m++) begin
        @(posedge clk_i);
        mode <= m[2:0];
        cyc(3);
        chk(src, ((i < 3 && m < 5) || m == 1) ? 8'h01 : 8'h00);
      end
    end
    rd(4'h4, 8'h19);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      mode <= 3'h1;
      vdd <= 8'h81 + i[7:0];
      cyc(3);
      chk({surv, src}, i ? 8'h01 : 8'h02);
    end
    @(posedge clk_i);
    run_i <= 1'b0;
    cyc(8);
    chk({rsw, ls, hs, src}, 8'h00);
    @(posedge clk_i);
    run_i <= 1'b1;
    cyc(2);
    chk({rsw, ls, hs}, 8'h05);
    cyc(8);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      gr <= 8'h96 + i[7:0];
      cyc(3);
      chk({flt, rgw, rsw}, i ? 8'h04 : 8'h03);
    end
    rd(4'h6, 8'h02);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      gr <= 8'h82;
      vdd <= 8'h6A - i[7:0];
      cyc(4);
      chk({flt, ssw}, i ? 8'h01 : 8'h02);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      {opn, sht} <= i ? 2'b01 : 2'b10;
      vdd <= 8'h80;
      cyc(3);
      chk(flt, 8'h01);
      rd(4'h6, 8'h01);
      @(posedge clk_i);
      {opn, sht} <= 2'b00;
      vdd <= 8'h69;
      cyc(4);
      chk(flt, 8'h00);
    end
    foreach (vth[i]) begin
      @(posedge clk_i);
      vdd <= vth[i];
      cyc(4);
      chk(ssw, (i == 0 || i == 3) ? 8'h01 : 8'h00);
    end
    summarize();
  end
endmodule
